// ==== hdl/smpmc_top.sv ====
// supply monitor status and power-saving mode sequencer
module smpmc_top
  import smpmc_pkg::*;
#(
  parameter int DLY_W = 10
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // reset cause and power-on
  input wire logic por_i,
  input wire logic lvd_reset_i,
  // analog warning comparator at the selected threshold
  input wire logic avd_below_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // processor core
  input wire logic wfi_i,
  input wire logic halt_i,
  input wire logic irq_pending_i,
  input wire logic halt_wake_irq_i,
  input wire logic timer_irq_i,
  input wire logic avd_irq_ack_i,
  // interrupt and sequencing outputs
  output logic avd_irq_o,
  output logic imask_clr_o,
  output logic svc_irq_o,
  output logic fetch_rst_o,
  output logic wdg_reset_o,
  // clock gating, clock and detector settings, mode
  output logic osc_en_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic timer_clk_en_o,
  output logic [1:0] avd_thresh_o,
  output logic avd_en_o,
  output logic [2:0] rc_prescale_o,
  output logic [1:0] osc_trim_low_o,
  output logic [4:0] mode_o
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wb_ack_ff;
  wire [7:0] idx = wb_adr_i[ADR_W-1:2];
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_ff;
  // writes land at the edge where the master samples ack high
  wire wr_lane0 = wb_cyc_i && wb_stb_i && wb_ack_ff && wb_we_i && wb_sel_i[0];
  wire rd = req && !wb_we_i;
  wire hit_si = (idx == SUPPLY_INTEGRITY_STATUS_CTRL_IDX);
  wire hit_th = (idx == THCR_IDX);
  wire hit_pc = (idx == PCTL_IDX);
  wire hit_ps = (idx == PSTAT_IDX);
  wire wr_si = wr_lane0 && hit_si;
  wire wr_th = wr_lane0 && hit_th;
  wire wr_pc = wr_lane0 && hit_pc;
  wire rd_si = rd && hit_si;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] wb_dat_ff;
  logic avd_en_ff;
  logic lowvolt_reset_flag_ff;
  logic supply_warning_flag_ff;
  logic supply_warning_irq_enable_ff;
  logic [1:0] trim_ff;
  logic [1:0] avd_ff;
  logic [2:0] ck_ff;
  logic [7:0] pctl_ff;
  logic pend_ff;
  smpmc_state_t state_ff;
  smpmc_state_t nxt_state;
  logic start_rst_ff;
  logic nxt_start_rst;
  logic imask_clr_ff;
  logic svc_irq_ff;
  logic fetch_rst_ff;
  logic wdg_reset_ff;
  logic osc_en_ff;
  logic periph_en_ff;
  logic timer_en_ff;

  // ---------------------------------------------------------------
  // power control fields
  // ---------------------------------------------------------------
  wire slow = pctl_ff[PC_SLOW];
  wire timebase_irq_enable = pctl_ff[PC_TIMEBASE_IRQ_ENABLE];
  wire overflow_irq_enable = pctl_ff[PC_OVERFLOW_IRQ_ENABLE];
  wire [1:0] tck = pctl_ff[PC_TCK_LSB +: 2];
  wire wdg_halt_opt = pctl_ff[PC_WATCHDOG_HALT_OPTION];
  wire wdg_en = pctl_ff[PC_WDGEN];
  wire [DLY_W-1:0] dly_len = pctl_ff[PC_DLY512] ? DLY_W'(DLY_LONG) : DLY_W'(DLY_SHORT);

  wire in_halt = (state_ff == ST_HALT);
  wire active_halt_sel = timebase_irq_enable || (overflow_irq_enable && (tck == TCK_ACTIVE_HALT));
  wire halt_wdg_rst = wdg_en && wdg_halt_opt;

  // ---------------------------------------------------------------
  // supply-warning flag and interrupt
  // ---------------------------------------------------------------
  // comparator output is masked when the detector is switched off
  wire avd_on = (avd_ff != AVD_OFF);
  wire nxt_supply_warning_flag = in_halt ? supply_warning_flag_ff : (avd_on && avd_below_i);
  wire avd_rise = nxt_supply_warning_flag && !supply_warning_flag_ff;
  wire avd_set = avd_rise && supply_warning_irq_enable_ff;
  // set wins over the service acknowledge in the same cycle
  wire nxt_pend = avd_set || (pend_ff && !avd_irq_ack_i);

  // low-voltage reset flag: kept through other resets except power-on, cleared by power-on or read
  wire nxt_lowvolt_reset_flag = lvd_reset_i ? 1'b1 : (por_i ? 1'b0 : lowvolt_reset_flag_ff);
  wire lowvolt_reset_flag_rd_clr = rd_si && !in_halt;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [7:0] si_val = {1'b0, trim_ff, 2'b00, lowvolt_reset_flag_ff, supply_warning_flag_ff, supply_warning_irq_enable_ff};
  wire [7:0] th_val = {ck_ff, 3'b000, avd_ff};
  wire [7:0] ps_val = {3'b000, state_ff};
  wire [7:0] rd_val = hit_si ? si_val :
                      hit_th ? th_val :
                      hit_pc ? pctl_ff :
                      hit_ps ? ps_val : 8'h00;

  // ---------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------
  wire dly_done;
  wire start_dly = (state_ff != ST_START) && (nxt_state == ST_START);
  wire wait_wake = irq_pending_i || pend_ff;
  wire enter_sleep = (state_ff == ST_RUN) && (nxt_state != ST_RUN);

  always_comb begin
    nxt_state = state_ff;
    nxt_start_rst = start_rst_ff;
    case (state_ff)
      ST_RUN: begin
        if (wfi_i) begin
          nxt_state = ST_WAIT;
        end else if (halt_i && !halt_wdg_rst) begin
          nxt_state = active_halt_sel ? ST_AHALT : ST_HALT;
        end
      end
      ST_WAIT: begin
        if (wait_wake) begin
          nxt_state = ST_RUN;
        end
      end
      ST_AHALT: begin
        if (timer_irq_i) begin
          nxt_state = ST_RUN;
        end
      end
      ST_HALT: begin
        if (halt_wake_irq_i) begin
          nxt_state = ST_START;
          nxt_start_rst = 1'b0;
        end
      end
      ST_START: begin
        if (dly_done) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_START;
        nxt_start_rst = 1'b1;
      end
    endcase
  end

  // wake-up service pulse: to run from a sleep state or a delayed wake
  wire nxt_svc = (nxt_state == ST_RUN) && (state_ff != ST_RUN) &&
                 !((state_ff == ST_START) && start_rst_ff);
  wire nxt_fetch = (state_ff == ST_START) && dly_done && start_rst_ff;

  // oscillator stays off only in halt
  wire nxt_osc = (nxt_state != ST_HALT);
  wire nxt_periph = (nxt_state == ST_RUN) || (nxt_state == ST_WAIT);
  wire nxt_timer = nxt_periph || (nxt_state == ST_AHALT);
  wire cpu_run = (nxt_state == ST_RUN);

  // ---------------------------------------------------------------
  // sequential logic
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
    end else begin
      wb_ack_ff <= req;
      wb_dat_ff <= rd ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  // lvd flag survives system reset; only power-on or a read clears it
  always_ff @(posedge clk_sys_i) begin
    if (lowvolt_reset_flag_rd_clr && !lvd_reset_i) begin
      lowvolt_reset_flag_ff <= 1'b0;
    end else begin
      lowvolt_reset_flag_ff <= nxt_lowvolt_reset_flag;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      supply_warning_flag_ff <= 1'b0;
      supply_warning_irq_enable_ff <= 1'b0;
      trim_ff <= SI_RST_CR;
      pend_ff <= 1'b0;
    end else begin
      supply_warning_flag_ff <= nxt_supply_warning_flag;
      pend_ff <= nxt_pend;
      if (wr_si && !in_halt) begin
        supply_warning_irq_enable_ff <= wb_dat_i[SI_SUPPLY_WARNING_IRQ_ENABLE];
        trim_ff <= wb_dat_i[SI_CR_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      avd_ff <= TH_RST_AVD;
      ck_ff <= TH_RST_CK;
      pctl_ff <= PC_RST;
      avd_en_ff <= 1'b0;
    end else begin
      avd_en_ff <= avd_on;
      if (wr_th) begin
        avd_ff <= wb_dat_i[1:0];
        ck_ff <= wb_dat_i[TH_CK_LSB +: 3];
      end
      if (wr_pc) begin
        pctl_ff <= wb_dat_i[7:0];
      end
    end
  end

  // every reset, including one that ends active-halt, runs the delay
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_ff <= ST_START;
      start_rst_ff <= 1'b1;
      imask_clr_ff <= 1'b0;
      svc_irq_ff <= 1'b0;
      fetch_rst_ff <= 1'b0;
      wdg_reset_ff <= 1'b0;
      osc_en_ff <= 1'b1;
      periph_en_ff <= 1'b0;
      timer_en_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      start_rst_ff <= nxt_start_rst;
      imask_clr_ff <= enter_sleep;
      svc_irq_ff <= nxt_svc;
      fetch_rst_ff <= nxt_fetch;
      wdg_reset_ff <= (state_ff == ST_RUN) && halt_i && !wfi_i && halt_wdg_rst;
      osc_en_ff <= nxt_osc;
      periph_en_ff <= nxt_periph;
      timer_en_ff <= nxt_timer;
    end
  end

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  smpmc_delay #(
    .W(DLY_W)
  ) u_delay (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .start_i(start_dly),
    .len_i(dly_len),
    .done_o(dly_done)
  );

  // cpu clock stops in wait and both halts, slowed by 32 in slow mode
  smpmc_clkdiv #(
    .DIV(SLOW_DIV)
  ) u_div (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .run_i(cpu_run),
    .slow_i(slow),
    .tick_o(cpu_clk_en_o)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign avd_irq_o = pend_ff;
  assign imask_clr_o = imask_clr_ff;
  assign svc_irq_o = svc_irq_ff;
  assign fetch_rst_o = fetch_rst_ff;
  assign wdg_reset_o = wdg_reset_ff;
  assign osc_en_o = osc_en_ff;
  assign periph_clk_en_o = periph_en_ff;
  assign timer_clk_en_o = timer_en_ff;
  assign avd_thresh_o = avd_ff;
  assign avd_en_o = avd_en_ff;
  assign rc_prescale_o = ck_ff;
  assign osc_trim_low_o = trim_ff;
  assign mode_o = state_ff;

endmodule

// ==== hdl/smpmc_pkg.sv ====
// constants for the supply monitor and power mode controller
package smpmc_pkg;

  // register indexes; byte address on the bus is four times the index
  localparam logic [7:0] SUPPLY_INTEGRITY_STATUS_CTRL_IDX = 8'h3a;
  localparam logic [7:0] THCR_IDX = 8'h3e;
  localparam logic [7:0] PCTL_IDX = 8'h40;
  localparam logic [7:0] PSTAT_IDX = 8'h41;
  localparam int ADR_W = 10;

  // supply_integrity_status_ctrl fields
  localparam int SI_CR_LSB = 5;
  localparam int SI_LOWVOLT_RESET_FLAG = 2;
  localparam int SI_SUPPLY_WARNING_FLAG = 1;
  localparam int SI_SUPPLY_WARNING_IRQ_ENABLE = 0;
  localparam logic [1:0] SI_RST_CR = 2'h3;

  // supply_warning_threshold_sel fields
  localparam int TH_CK_LSB = 5;
  localparam logic [2:0] TH_RST_CK = 3'h0;
  localparam logic [1:0] TH_RST_AVD = 2'h3;
  localparam logic [1:0] AVD_LOW = 2'h0;
  localparam logic [1:0] AVD_MED = 2'h1;
  localparam logic [1:0] AVD_HIGH = 2'h2;
  localparam logic [1:0] AVD_OFF = 2'h3;

  // power control register fields
  localparam int PC_SLOW = 0;
  localparam int PC_TIMEBASE_IRQ_ENABLE = 1;
  localparam int PC_OVERFLOW_IRQ_ENABLE = 2;
  localparam int PC_TCK_LSB = 3;
  localparam int PC_WATCHDOG_HALT_OPTION = 5;
  localparam int PC_WDGEN = 6;
  localparam int PC_DLY512 = 7;
  localparam logic [7:0] PC_RST = 8'h00;
  localparam logic [1:0] TCK_ACTIVE_HALT = 2'h1;

  // timing counts in main oscillator cycles
  localparam int SLOW_DIV = 32;
  localparam int DLY_SHORT = 256;
  localparam int DLY_LONG = 512;

  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_WAIT = 5'h02,
    ST_AHALT = 5'h04,
    ST_HALT = 5'h08,
    ST_START = 5'h10
  } smpmc_state_t;

endpackage

// ==== hdl/smpmc_clkdiv.sv ====
// cpu clock enable divider for slow mode; peripheral clock enable is not divided
module smpmc_clkdiv
  import smpmc_pkg::*;
#(
  parameter int DIV = SLOW_DIV
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // control
  input wire logic run_i,
  input wire logic slow_i,
  // enable out
  output logic tick_o
);
  initial begin
    if (DIV < 2) begin
      $error("divider must be at least 2");
    end
  end

  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_ff;
  logic tick_ff;
  wire wrap = (cnt_ff == CW'(DIV - 1));
  wire [CW-1:0] nxt_cnt = (wrap || !slow_i) ? '0 : cnt_ff + CW'(1);
  wire nxt_tick = run_i && (!slow_i || wrap);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;
endmodule

// ==== hdl/smpmc_delay.sv ====
// restart stabilisation delay counter
module smpmc_delay
  import smpmc_pkg::*;
#(
  parameter int W = 10
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // control
  input wire logic start_i,
  input wire logic [W-1:0] len_i,
  // status
  output logic done_o
);
  initial begin
    if ((1 << W) <= DLY_LONG) begin
      $error("delay counter too narrow");
    end
  end

  logic [W-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  wire last = busy_ff && (cnt_ff == W'(1));

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      // reset preloads the count so the startup delay runs from release
      cnt_ff <= len_i;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (start_i) begin
      cnt_ff <= len_i;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= busy_ff ? cnt_ff - W'(1) : cnt_ff;
      busy_ff <= busy_ff && !last;
      done_ff <= last;
    end
  end

  assign done_o = done_ff;
endmodule

// ==== test/smpmc_chk.sv ====
// assertion checker for the power mode sequencer ports
module smpmc_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // core side
  input wire logic wfi_i,
  input wire logic halt_i,
  input wire logic irq_pending_i,
  input wire logic halt_wake_irq_i,
  input wire logic timer_irq_i,
  // sequencing outputs
  input wire logic imask_clr_o,
  input wire logic svc_irq_o,
  input wire logic wdg_reset_o,
  input wire logic osc_en_o,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic timer_clk_en_o,
  input wire logic [4:0] mode_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack slip");
  property p_wait_in; mode_o == 5'h01 && wfi_i |=> mode_o == 5'h02 && imask_clr_o; endproperty
  a_wait_in: assert property (p_wait_in) else $error("wait entry slip");
  property p_wait_out; mode_o == 5'h02 && irq_pending_i |=> mode_o == 5'h01 && svc_irq_o; endproperty
  a_wait_out: assert property (p_wait_out) else $error("wait exit slip");
  property p_halt_in;
    mode_o == 5'h01 && halt_i && !wfi_i |=>
      imask_clr_o && (mode_o == 5'h04 || mode_o == 5'h08) || wdg_reset_o && mode_o == 5'h01;
  endproperty
  a_halt_in: assert property (p_halt_in) else $error("halt entry slip");
  property p_ahalt; mode_o == 5'h04 |-> osc_en_o && timer_clk_en_o && !periph_clk_en_o && !cpu_clk_en_o; endproperty
  a_ahalt: assert property (p_ahalt) else $error("active-halt clocks");
  property p_ahalt_out; mode_o == 5'h04 && timer_irq_i |=> mode_o == 5'h01 && svc_irq_o; endproperty
  a_ahalt_out: assert property (p_ahalt_out) else $error("active-halt exit");
  property p_halt_off; mode_o == 5'h08 |-> !(osc_en_o || periph_clk_en_o || timer_clk_en_o || cpu_clk_en_o); endproperty
  a_halt_off: assert property (p_halt_off) else $error("halt clocks");
  property p_halt_stay; mode_o == 5'h08 && !halt_wake_irq_i |=> mode_o == 5'h08; endproperty
  a_halt_stay: assert property (p_halt_stay) else $error("halt left early");
  property p_halt_out;
    mode_o == 5'h08 && halt_wake_irq_i |=> mode_o == 5'h10 && osc_en_o ##[250:520] mode_o == 5'h01;
  endproperty
  a_halt_out: assert property (p_halt_out) else $error("halt exit slip");
endmodule

bind smpmc_top smpmc_chk u_chk (.clk_sys_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wfi_i, .halt_i,
  .irq_pending_i, .halt_wake_irq_i, .timer_irq_i, .imask_clr_o, .svc_irq_o, .wdg_reset_o, .osc_en_o,
  .cpu_clk_en_o, .periph_clk_en_o, .timer_clk_en_o, .mode_o);

// ==== test/smpmc_core_model.sv ====
// processor core model driving power-mode instructions and wake lines
module smpmc_core_model (
  // clock
  input wire logic clk_sys_i,
  // from the sequencer
  input wire logic avd_irq_i,
  input wire logic svc_irq_i,
  // to the sequencer
  output logic wfi_o,
  output logic halt_o,
  output logic irq_pend_o,
  output logic wake_o,
  output logic tmr_o,
  output logic ack_o
);
  int lag;
  initial begin
    {wfi_o, halt_o, wake_o, tmr_o, ack_o} = 5'h00;
    lag = 0;
  end
  assign irq_pend_o = avd_irq_i;
  // a slow core reaches the routine entry a few cycles after the vector
  always @(posedge clk_sys_i) begin
    ack_o <= (lag == 1);
    lag <= (svc_irq_i === 1'b1 && avd_irq_i === 1'b1) ? 4 : (lag > 0 ? lag - 1 : 0);
  end
  // halt is issued only by an explicit call, never fetched from stored data
  task automatic instr(input logic w, input logic h);
    @(posedge clk_sys_i);
    wfi_o <= w;
    halt_o <= h;
    @(posedge clk_sys_i);
    wfi_o <= 1'b0;
    halt_o <= 1'b0;
  endtask
  task automatic lines(input logic w, input logic t);
    @(posedge clk_sys_i);
    wake_o <= w;
    tmr_o <= t;
  endtask
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the supply monitor and power mode controller
module testbench
  import smpmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i, resetn_i, por, low_voltage_detector, below, cyc, stb, we, wait_for_interrupt_instr, halt, pend, wake, tmr, ack;
  logic wb_ack_o, avd_irq_o, svc_irq_o, wdg_reset_o, cpu_clk_en_o, avd_en_o;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, wb_dat_o;
  logic [1:0] avd_thresh_o, osc_trim_low_o;
  logic [2:0] rc_prescale_o;
  logic [4:0] mode_o;
  logic [7:0] v;
  logic [31:0] exp_q[$];
  logic [7:0] hc[6] = '{8'h02, 8'h0c, 8'h42, 8'h1c, 8'h84, 8'h60};
  logic [4:0] hm[6] = '{5'h04, 5'h04, 5'h04, 5'h08, 5'h08, 5'h01};
  int err_count, check_count, n, cnt;

  smpmc_top dut (.clk_sys_i, .resetn_i, .por_i(por), .lvd_reset_i(low_voltage_detector), .avd_below_i(below), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o,
    .wfi_i(wait_for_interrupt_instr), .halt_i(halt), .irq_pending_i(pend), .halt_wake_irq_i(wake), .timer_irq_i(tmr),
    .avd_irq_ack_i(ack), .avd_irq_o, .imask_clr_o(), .svc_irq_o, .fetch_rst_o(), .wdg_reset_o, .osc_en_o(),
    .cpu_clk_en_o, .periph_clk_en_o(), .timer_clk_en_o(), .avd_thresh_o, .avd_en_o, .rc_prescale_o,
    .osc_trim_low_o, .mode_o);
  smpmc_core_model core (.clk_sys_i, .avd_irq_i(avd_irq_o), .svc_irq_i(svc_irq_o), .wfi_o(wait_for_interrupt_instr), .halt_o(halt),
    .irq_pend_o(pend), .wake_o(wake), .tmr_o(tmr), .ack_o(ack));

  task automatic wrap_up();
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [7:0] e);
    int k;
    if (!w) exp_q.push_back({24'h0, e});
    @(posedge clk_sys_i);
    {cyc, stb, we, sel} <= {2'h3, w, 4'hf};
    adr <= {i, 2'h0};
    wdat <= {24'($urandom), d};
    k = 0;
    do begin @(posedge clk_sys_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin err_count++; wrap_up(); end
    {cyc, stb} <= 2'h0;
  endtask
  task automatic wait_mode(input logic [4:0] m, output int k);
    k = 0;
    while (mode_o !== m && k < 3000) begin @(negedge clk_sys_i); k++; end
    if (k >= 3000) begin err_count++; wrap_up(); end
  endtask
  task automatic do_reset(input logic l);
    @(posedge clk_sys_i);
    {resetn_i, low_voltage_detector, por} <= {1'b0, l, l};
    repeat (12) @(posedge clk_sys_i);
    {resetn_i, low_voltage_detector, por} <= 3'h4;
  endtask
  task automatic halt_case(input logic [7:0] c, input logic [4:0] m);
    int k, d;
    d = c[7] ? 512 : 256;
    bus(1, PCTL_IDX, c, 0);
    core.instr(0, 1);
    k = 0;
    repeat (3) begin @(negedge clk_sys_i); k += (wdg_reset_o === 1'b1); end
    chk(mode_o, m);
    chk(k, c[6] & c[5]);
    if (m == 5'h08) begin
      bus(1, SUPPLY_INTEGRITY_STATUS_CTRL_IDX, 8'h20, 0);
      core.lines(1, 0);
      wait_mode(5'h10, k);
      core.lines(0, 0);
      wait_mode(5'h01, k);
      chk(k + 4 >= d && k <= d + 4, 1'b1);
    end else begin
      core.lines(0, m == 5'h04);
      wait_mode(5'h01, k);
      chk(k < 4, 1'b1);
    end
    core.lines(0, 0);
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // read data is judged against the oldest expectation when the answer shows
  always @(posedge clk_sys_i) if (wb_ack_o === 1'b1 && we === 1'b0) chk(wb_dat_o, exp_q.pop_front());

  initial begin
    {resetn_i, por, low_voltage_detector, below, cyc, stb, we} = 7'h20;
    {adr, sel, wdat} = '0;
    err_count = 0;
    check_count = 0;
    void'($urandom(85));
    do_reset(1);
    @(negedge clk_sys_i);
    chk({mode_o, avd_thresh_o, avd_en_o}, {5'h10, 2'h3, 1'b0});
    do_reset(0);
    wait_mode(5'h01, n);
    chk(n >= 250 && n <= 262, 1'b1);
    bus(1, SUPPLY_INTEGRITY_STATUS_CTRL_IDX, 8'h20, 0);
    bus(0, SUPPLY_INTEGRITY_STATUS_CTRL_IDX, 0, 8'h24);
    bus(0, SUPPLY_INTEGRITY_STATUS_CTRL_IDX, 0, 8'h20);
    chk(osc_trim_low_o, 2'h1);
    bus(0, THCR_IDX, 0, 8'h03);
    bus(0, 8'h10, 0, 8'h00);
    for (int c = 0; c < 4; c++) begin
      v = {3'($urandom), 3'h0, 2'(c)};
      bus(1, THCR_IDX, v, 0);
      bus(0, THCR_IDX, 0, v);
      chk({rc_prescale_o, avd_thresh_o, avd_en_o}, {v[7:5], v[1:0], c != 3});
    end
    bus(1, THCR_IDX, 8'h00, 0);
    bus(1, PCTL_IDX, 8'h01, 0);
    cnt = 0;
    repeat (320) begin @(negedge clk_sys_i); cnt += (cpu_clk_en_o === 1'b1); end
    chk(cnt, 10);
    bus(1, SUPPLY_INTEGRITY_STATUS_CTRL_IDX, 8'h21, 0);
    core.instr(1, 0);
    wait_mode(5'h02, n);
    @(posedge clk_sys_i) below <= 1'b1;
    wait_mode(5'h01, n);
    chk(n < 12, 1'b1);
    repeat (8) @(negedge clk_sys_i);
    chk(avd_irq_o, 1'b0);
    bus(0, SUPPLY_INTEGRITY_STATUS_CTRL_IDX, 0, 8'h23);
    @(posedge clk_sys_i) below <= 1'b0;
    bus(1, SUPPLY_INTEGRITY_STATUS_CTRL_IDX, 8'h23, 0);
    bus(0, SUPPLY_INTEGRITY_STATUS_CTRL_IDX, 0, 8'h21);
    foreach (hc[i]) halt_case(hc[i], hm[i]);
    bus(0, SUPPLY_INTEGRITY_STATUS_CTRL_IDX, 0, 8'h21);
    wrap_up();
  end
endmodule
